// File: hw/mac_word_pkg.sv
// Package for the normal-word multiply-accumulate datapath.
// Assumes a single clock; shared by the datapath and the bench.
package mac_word_pkg;

  localparam int OPW  = 32;  // Operand width
  localparam int ACCW = 64;  // Accumulator pair width
  localparam int EXTW = 16;  // Extension bits per pair
  localparam int SUMW = 80;  // Full accumulation width

  // Extension register field positions
  localparam int EXT_LO_LSB = 0;
  localparam int EXT_HI_LSB = 16;

  // Range limits for the sticky overflow check, as exponents of two
  localparam int SFRAC_EXP = 15;
  localparam int SINT_EXP  = 79;
  localparam int UFRAC_EXP = 16;
  localparam int SGL_SEXP  = 31;
  localparam int SGL_UEXP  = 32;

  // Reset values
  localparam logic [ACCW-1:0] ACC_RESET = 64'h0;
  localparam logic [31:0]     EXT_RESET = 32'h0;

  // Instruction prefix: which compute block executes
  typedef enum logic [1:0] {
    BLK_FIRST  = 2'h1,
    BLK_SECOND = 2'h2,
    BLK_BOTH   = 2'h3
  } blk_sel_t;

  // One issued operation
  typedef struct packed {
    logic     valid;      // Issue strobe
    blk_sel_t blkSel;     // Prefix selection
    logic     accumSelect;// 0: low pair, 1: high pair
    logic     sub;        // Subtract form
    logic     isUnsigned; // Unsigned operands (add only)
    logic     isInteger;  // Integer data
    logic     clear;      // Zero accumulator first
    logic     zeroThenRound; // Clear-and-round variant
    logic     dual;       // Move old value to the register file
    logic     destPair;   // Dual destination is a register pair
  } mac_op_t;

  // The two multiplier operands of one compute block
  typedef struct packed {
    logic [OPW-1:0] firstOperandReg;
    logic [OPW-1:0] secondOperandReg;
  } mac_operands_t;

  // Write to the register file from the dual form
  typedef struct packed {
    logic            valid;
    logic            pair;
    logic [ACCW-1:0] data;
  } rf_write_t;

endpackage

// File: hw/mac_word_accumulator.sv
// Normal-word multiply-accumulate for two compute blocks.
// Assumes issue logic on the same clock presents one op per cycle.
//
// Contract
// - Multiply two 32-bit operands, add or subtract product to accumulator.
// - 80-bit result goes back into the pair that supplied the addend.
// - Pairs hold 64 bits; extension low half for low pair, high half else.
// - Sticky overflow judged on final sum; other flags untouched.
// - Signed fraction overflows at or above 2^15 or below -2^15.
// - Signed integer overflows at or above 2^79 or below -2^79.
// - Unsigned fraction, add only, overflows at or above 2^16.
// - Unsigned integer, add only, overflows at or above 2^80.
// - Clear option zeroes accumulator before accumulating; clear-round too.
// - Dual form copies old accumulator to destination register.
// - Dual clear zeroes after old value is moved, before adding product.
// - Dual-form transfer is truncated, never rounded.
// - Pair destination receives full 64-bit accumulator.
// - Single destination gets low half for integer, upper for fraction.
// - Signed integer single move flags old value outside 32-bit signed.
// - Unsigned integer single move flags old value at or above 2^32.
// - Sticky overflow stays set until software clears it.
`timescale 1ns/100ps

module mac_word_accumulator (
  input  wire logic                      clk,        // 10 MHz clock
  input  wire logic                      rst_n,      // Sync reset, low
  input  wire mac_word_pkg::mac_op_t     op,         // Issued operation
  input  wire mac_word_pkg::mac_operands_t opA,      // First block operands
  input  wire mac_word_pkg::mac_operands_t opB,      // Second block operands
  input  wire logic [1:0]                stickyClear,// Per-block flag clear
  output logic [127:0]                   accumPairLow,  // Low pairs B,A
  output logic [127:0]                   accumPairHigh, // High pairs B,A
  output logic [63:0]                    accumExtension,// Extension B,A
  output logic [1:0]                     overflowSticky,// Sticky flags B,A
  output mac_word_pkg::rf_write_t        rfWriteA,   // First block move
  output mac_word_pkg::rf_write_t        rfWriteB    // Second block move
);

  localparam int SW = mac_word_pkg::SUMW;

  // Range check of the final 80-bit sum per data type
  function automatic logic sumOver(input logic [SW:0] s,
                                   input logic uns, input logic intg);
    logic signed [SW:0] ss;
    ss = signed'(s);
    if (uns && intg) begin
      sumOver = s[SW];
    end else if (uns) begin
      sumOver = (s >= (81'h1 << mac_word_pkg::UFRAC_EXP));
    end else if (intg) begin
      sumOver = (ss >= (81'sh1 <<< mac_word_pkg::SINT_EXP)) ||
                (ss < -(81'sh1 <<< mac_word_pkg::SINT_EXP));
    end else begin
      sumOver = (ss >= (81'sh1 <<< mac_word_pkg::SFRAC_EXP)) ||
                (ss < -(81'sh1 <<< mac_word_pkg::SFRAC_EXP));
    end
  endfunction

  logic [1:0] blkEn;
  assign blkEn = {op.valid && op.blkSel[1], op.valid && op.blkSel[0]};

  logic [1:0][63:0] accLo_reg, accLo_next, accHi_reg, accHi_next;
  logic [1:0][31:0] ext_reg, ext_next;
  logic [1:0]       sticky_reg, sticky_next;
  mac_word_pkg::rf_write_t [1:0] rf_reg, rf_next;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gBlk
      mac_word_pkg::mac_operands_t ops;
      assign ops = (g == 0) ? opA : opB;

      // Per-block datapath: old value, product, new sum and flag
      always_comb begin
        logic [SW-1:0] oldVal, addend, prod, sumVal;
        logic [SW:0]   fullSum;
        logic [63:0]   oldPair;
        logic [15:0]   oldExt;
        logic signed [SW-1:0] sOld;
        logic          ovf;
        // Every local gets a value first so no path leaves a latch behind
        oldVal  = '0;
        addend  = '0;
        prod    = '0;
        sumVal  = '0;
        fullSum = '0;
        oldPair = '0;
        oldExt  = '0;
        sOld    = '0;
        ovf     = 1'b0;
        accLo_next[g]  = accLo_reg[g];
        accHi_next[g]  = accHi_reg[g];
        ext_next[g]    = ext_reg[g];
        rf_next[g]     = '0;
        oldPair = op.accumSelect ? accHi_reg[g] : accLo_reg[g];
        oldExt  = op.accumSelect ? ext_reg[g][31:16] : ext_reg[g][15:0];
        oldVal  = {oldExt, oldPair};
        sOld    = signed'(oldVal);
        // Clear precedes the add; in dual form it follows the move
        addend  = (op.clear || op.zeroThenRound) ? '0 : oldVal;
        if (op.isUnsigned) begin
          prod = {48'h0, ops.firstOperandReg} * {48'h0, ops.secondOperandReg};
        end else begin
          prod = SW'(signed'({{48{ops.firstOperandReg[31]}},
                 ops.firstOperandReg}) *
                 signed'({{48{ops.secondOperandReg[31]}},
                 ops.secondOperandReg}));
        end
        // Unsigned forms are add only; subtract uses the signed sum
        if (op.sub && !op.isUnsigned) begin
          fullSum = {addend[SW-1], addend} - {prod[SW-1], prod};
        end else if (op.isUnsigned) begin
          fullSum = {1'b0, addend} + {1'b0, prod};
        end else begin
          fullSum = {addend[SW-1], addend} + {prod[SW-1], prod};
        end
        sumVal = fullSum[SW-1:0];
        ovf = sumOver(fullSum, op.isUnsigned, op.isInteger);
        // Single-register move range checks on the old value
        if (op.dual && !op.destPair && op.isInteger) begin
          if (op.isUnsigned) begin
            ovf = ovf || (oldVal >= (80'h1 << mac_word_pkg::SGL_UEXP));
          end else begin
            ovf = ovf ||
                  (sOld >= (80'sh1 <<< mac_word_pkg::SGL_SEXP)) ||
                  (sOld < -(80'sh1 <<< mac_word_pkg::SGL_SEXP));
          end
        end
        if (blkEn[g]) begin
          // Result returns to the pair it came from
          if (op.accumSelect) begin
            accHi_next[g] = sumVal[63:0];
            ext_next[g][31:16] = sumVal[79:64];
          end else begin
            accLo_next[g] = sumVal[63:0];
            ext_next[g][15:0] = sumVal[79:64];
          end
          if (op.dual) begin
            rf_next[g].valid = 1'b1;
            rf_next[g].pair  = op.destPair;
            // Plain bit selection: truncated, no rounding
            if (op.destPair) begin
              rf_next[g].data = oldPair;
            end else if (op.isInteger) begin
              rf_next[g].data = {32'h0, oldPair[31:0]};
            end else begin
              rf_next[g].data = {32'h0, oldPair[63:32]};
            end
          end
        end
        // Set wins over a same-cycle clear
        sticky_next[g] = (sticky_reg[g] && !stickyClear[g]) ||
                         (blkEn[g] && ovf);
      end
    end
  endgenerate

  // Register all block state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accLo_reg  <= {2{mac_word_pkg::ACC_RESET}};
      accHi_reg  <= {2{mac_word_pkg::ACC_RESET}};
      ext_reg    <= {2{mac_word_pkg::EXT_RESET}};
      sticky_reg <= 2'h0;
      rf_reg     <= '0;
    end else begin
      accLo_reg  <= accLo_next;
      accHi_reg  <= accHi_next;
      ext_reg    <= ext_next;
      sticky_reg <= sticky_next;
      rf_reg     <= rf_next;
    end
  end

  assign accumPairLow   = accLo_reg;
  assign accumPairHigh  = accHi_reg;
  assign accumExtension = ext_reg;
  assign overflowSticky = sticky_reg;
  assign rfWriteA       = rf_reg[0];
  assign rfWriteB       = rf_reg[1];

endmodule // mac_word_accumulator

// File: verif/mac_word_monitor.sv
// Port checker for the word multiply-accumulate, block A mostly.
// Assumes one clock; bound to the design below.
`timescale 1ns/100ps
module mac_word_monitor (
  input wire logic                        clk,            // Clock
  input wire logic                        rst_n,          // Reset
  input wire mac_word_pkg::mac_op_t       op,             // Op
  input wire mac_word_pkg::mac_operands_t opA,            // A regs
  input wire logic [1:0]                  stickyClear,    // Clear
  input wire logic [127:0]                accumPairLow,   // Low
  input wire logic [127:0]                accumPairHigh,  // High
  input wire logic [63:0]                 accumExtension, // Ext
  input wire logic [1:0]                  overflowSticky, // Flags
  input wire mac_word_pkg::rf_write_t     rfWriteA        // A move
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Block A issue; high pair seen as one 80-bit sum
  wire logic        goA = op.valid && op.blkSel[0];
  wire logic        sA = overflowSticky[0];
  wire logic [79:0] hiSum = {accumExtension[31:16], accumPairHigh[63:0]};
  // Outside the signed fraction range when bits 79:15 are not all equal
  wire logic        hiOvf = |hiSum[79:15] && !(&hiSum[79:15]);
  AST_MV: assert property (rfWriteA.valid |-> $past(goA && op.dual))
    else $error("move without a dual op");
  AST_PR: assert property (goA && op.dual && op.destPair && !op.accumSelect
    |=> rfWriteA.data == $past(accumPairLow[63:0])) else $error("pair move");
  AST_ST: assert property (sA && !stickyClear[0] |=> sA)
    else $error("sticky flag dropped");
  AST_ID: assert property (!op.valid |=> $stable(accumPairLow))
    else $error("low pairs moved while idle");
  AST_KP: assert property (goA && !op.accumSelect |=> $stable(hiSum))
    else $error("wrong pair written");
  AST_CL: assert property (goA && op.accumSelect && op.clear && !op.dual
    && opA.firstOperandReg == 32'h0 |=> hiSum == 80'h0) else $error("clear");
  AST_SF: assert property (goA && op.accumSelect && !op.isInteger
    && !op.isUnsigned |=> !hiOvf || sA) else $error("fraction overflow");
  AST_BQ: assert property (op.valid && op.blkSel == 2'h1
    |=> $stable(accumPairHigh[127:64])) else $error("block B moved");
  cover property (goA && op.dual && op.destPair);
  cover property ($rose(sA));
  cover property (op.valid && op.sub);
endmodule // mac_word_monitor
bind mac_word_accumulator mac_word_monitor i_mon (.clk(clk), .rst_n(rst_n),
  .op(op), .opA(opA), .stickyClear(stickyClear), .accumPairLow(accumPairLow),
  .accumPairHigh(accumPairHigh), .accumExtension(accumExtension),
  .overflowSticky(overflowSticky), .rfWriteA(rfWriteA));

// File: verif/mac_rf_model.sv
// Register file stand-in: keeps the last value moved out by block A.
// Assumes a one-cycle move pulse on the shared clock.
`timescale 1ns/100ps
module mac_rf_model (
  input  wire logic                    clk,      // Clock
  input  wire mac_word_pkg::rf_write_t rfWriteA, // Move from block A
  output logic [63:0]                  regA      // Last value moved
);
  // Holds between moves, so a lost pulse shows as a stale value
  always_ff @(posedge clk) if (rfWriteA.valid) regA <= rfWriteA.data;
endmodule // mac_rf_model

// File: verif/tb_top.sv
// Directed self-checking bench for the word multiply-accumulate.
// Assumes the package, design, bound checker and register file model.
`timescale 1ns/100ps
module tb_top;
  logic                        clk, rst_n;
  logic [1:0]                  stickyClear, overflowSticky;
  logic [127:0]                accumPairLow, accumPairHigh;
  logic [63:0]                 accumExtension, regA;
  mac_word_pkg::mac_op_t       op;
  mac_word_pkg::mac_operands_t opA, opB;
  mac_word_pkg::rf_write_t     rfWriteA;
  int                          errCount, numChecks, cycles;
  mac_word_accumulator i_dut (.clk(clk), .rst_n(rst_n), .op(op), .opA(opA),
    .opB(opB), .stickyClear(stickyClear), .accumPairLow(accumPairLow),
    .accumPairHigh(accumPairHigh), .accumExtension(accumExtension),
    .overflowSticky(overflowSticky), .rfWriteA(rfWriteA), .rfWriteB());
  mac_rf_model i_rf (.clk(clk), .rfWriteA(rfWriteA), .regA(regA));
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    numChecks++;
    if (seen !== exp) errCount++;
    if (seen !== exp) $display("wrong value at %0t: %h", $time, seen);
  endtask
  // Flags: hi sub uns int clr cr dual pair; answer lands one edge later
  task automatic mac(input logic [1:0] blk, input logic [7:0] f,
                     input logic [31:0] m, input logic [31:0] n);
    @(posedge clk);
    op <= {1'b1, blk, f};
    {opA, opB} <= {m, n, m, n};
    @(posedge clk) op <= '0;
    #1;
  endtask
  task automatic finalReport();
    if (errCount == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The run needs some 30 cycles; anything far past that is a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) errCount++;
    if (cycles == 2000) finalReport();
  end
  initial begin
    {errCount, numChecks, cycles} = '0;
    {rst_n, stickyClear, op, opA, opB} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    mac(2'h1, 8'h50, 32'h2, 32'h5);
    chk({accumExtension[15:0], accumPairLow[63:0]},
        80'hffff_ffff_ffff_ffff_fff6);
    mac(2'h1, 8'h50, 32'hffff_fff6, 32'h6);
    chk({accumExtension, accumPairLow[63:0]}, 128'h32);
    repeat (2) mac(2'h2, 8'hb0, 32'hf006_0054, 32'hf036_ac42);
    chk({accumExtension[63:48], accumPairHigh[127:64]},
        80'h1_c271_c629_76f9_0b50);
    // Dual move with clear: old low half out, zero, then add
    mac(2'h1, 8'h3a, 32'h2, 32'h5);
    chk({rfWriteA.data[31:0], accumPairLow[63:0]}, 96'h32_0000_0000_0000_000a);
    mac(2'h1, 8'h3a, 32'ha, 32'h6);
    chk({rfWriteA.valid, rfWriteA.data[31:0], accumPairLow[63:0]},
        97'h1_0000_000a_0000_0000_0000_003c);
    mac(2'h1, 8'h13, 32'h7d0, 32'hfa0);
    @(posedge clk);
    #1;
    chk({regA, accumPairLow[63:0]}, {64'h3c, 64'h7a_123c});
    mac(2'h1, 8'h14, 32'h3, 32'h4);
    chk(accumPairLow[63:0], 64'hc);
    // Fraction range on A high pair; flag holds until cleared
    mac(2'h1, 8'h80, 32'h100, 32'h100);
    mac(2'h1, 8'h88, 32'h0, 32'h0);
    chk(overflowSticky, 2'h1);
    @(posedge clk) stickyClear <= 2'h1;
    @(posedge clk) stickyClear <= 2'h0;
    #1;
    chk(overflowSticky, 2'h0);
    mac(2'h1, 8'h80, 32'hffff_ff00, 32'h100);
    chk(overflowSticky, 2'h1);
    finalReport();
  end
endmodule // tb_top
